// ==== hdl/apf_pkg.sv ====
package apf_pkg;
	// half bridges: A+, A-, B+, B-; two channels of two half bridges each
	localparam int HB_COUNT = 4;
	localparam int CH_COUNT = 2;
	// overload counter
	localparam int OVL_WIDTH = 6;
	localparam logic [5:0] OVL_MAX = 6'h3F;
	localparam logic [5:0] OVL_ZERO = 6'h00;
	// pulse injection every fourth frame
	localparam int INJECT_PERIOD = 4;
	localparam logic [1:0] INJECT_SLOT = 2'h0;
	// clip pulse width
	localparam int CLK_PERIOD_NS = 100;
	localparam int CLIP_PULSE_NS = 500;
	localparam int CLIP_PULSE_CYC = (CLIP_PULSE_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	localparam int CLIP_CNT_WIDTH = 4;
	// strap code values in kilohm
	localparam logic [7:0] STRAP_CB_0 = 8'h16;
	localparam logic [7:0] STRAP_CB_1 = 8'h18;
	localparam logic [7:0] STRAP_CB_2 = 8'h1B;
	localparam logic [7:0] STRAP_CB_3 = 8'h1E;
	localparam logic [7:0] STRAP_LT_0 = 8'h2F;
	localparam logic [7:0] STRAP_LT_1 = 8'h33;
	localparam logic [7:0] STRAP_LT_2 = 8'h38;
	localparam logic [7:0] STRAP_LT_3 = 8'h40;
	// threshold select codes: 0 = 16.3 A, 1 = 15.1 A, 2 = 13.5 A, 3 = 12.3 A
	localparam logic [1:0] THR_16A3 = 2'h0;
	localparam logic [1:0] THR_15A1 = 2'h1;
	localparam logic [1:0] THR_13A5 = 2'h2;
	localparam logic [1:0] THR_12A3 = 2'h3;
	localparam logic [1:0] THR_MIN = THR_12A3;
	// output configuration
	typedef enum logic [1:0] {
		APF_CFG_BRIDGE = 2'h0,
		APF_CFG_PARALLEL = 2'h1,
		APF_CFG_SINGLE = 2'h2
	} apf_cfg_t;
	// fault state machine
	typedef enum logic [2:0] {
		APF_ST_RESET = 3'h1,
		APF_ST_RUN = 3'h2,
		APF_ST_HALT = 3'h4
	} apf_state_t;
endpackage : apf_pkg

// ==== hdl/apf_strap_decode.sv ====
`timescale 1ns/100ps
`default_nettype none
module apf_strap_decode
	import apf_pkg::*;
(
	// strap value in kilohm
	input wire logic [7:0] strapValue,
	// decoded setting
	output logic perCycleMode,
	output logic [1:0] thresholdSel
);
	wire logic isCb0 = (strapValue == STRAP_CB_0);
	wire logic isCb1 = (strapValue == STRAP_CB_1);
	wire logic isCb2 = (strapValue == STRAP_CB_2);
	wire logic isCb3 = (strapValue == STRAP_CB_3);
	wire logic isLt0 = (strapValue == STRAP_LT_0);
	wire logic isLt1 = (strapValue == STRAP_LT_1);
	wire logic isLt2 = (strapValue == STRAP_LT_2);
	wire logic isLt3 = (strapValue == STRAP_LT_3);
	wire logic anyCb = isCb0 | isCb1 | isCb2 | isCb3;

	assign perCycleMode = anyCb;
	assign thresholdSel = (isCb0 | isLt0) ? THR_16A3 :
		(isCb1 | isLt1) ? THR_15A1 :
		(isCb2 | isLt2) ? THR_13A5 :
		(isCb3 | isLt3) ? THR_12A3 :
		THR_MIN;
endmodule : apf_strap_decode
`default_nettype wire

// ==== hdl/apf_clip_pulse.sv ====
`timescale 1ns/100ps
`default_nettype none
module apf_clip_pulse
	import apf_pkg::*;
#(
	parameter int PULSE_CYC = CLIP_PULSE_CYC
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// clip level in
	input wire logic clipActive,
	// pulse out, high while indication asserted
	output logic clipIndicate
);
	logic clipSeen;
	logic [CLIP_CNT_WIDTH-1:0] pulseCount;
	wire logic onset = clipActive & ~clipSeen;
	wire logic counting = (pulseCount != '0);

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			clipSeen <= 1'b0;
			pulseCount <= '0;
		end else begin
			clipSeen <= clipActive;
			if (onset)
				pulseCount <= CLIP_CNT_WIDTH'(PULSE_CYC);
			else if (counting)
				pulseCount <= pulseCount - 1'b1;
		end
	end

	// narrow pulse at onset, then level while clipping persists; self clears
	assign clipIndicate = counting | (clipActive & clipSeen &
		(pulseCount == '0));
endmodule : apf_clip_pulse
`default_nettype wire

// ==== hdl/apf_protect.sv ====
// Overview of operation
// - alert low on any shutdown fault
// - warning low above 125 C
// - both pins active low open drain
// - two pins encode fault and warning status
// - reset low forces alert released high
// - overcurrent mode per-cycle limit or latched
// - per-bridge flip, cleared at next frame
// - counter up on event, down otherwise
// - counter maximum shuts channel until reset
// - latched mode shuts on first event
// - strap value selects mode and threshold
// - invalid strap gives minimum threshold
// - inject narrow pulse every fourth frame
// - clip shown on warning, self clearing
// - clip onset gives 500 ns pulses
// - bridge imbalance forces counter to maximum
// - no DC protection in parallel, single
// - fault sets outputs high impedance at once
// - heat shutdown latched until reset
`timescale 1ns/100ps
`default_nettype none
module apf_protect
	import apf_pkg::*;
#(
	parameter int OVL_BITS = OVL_WIDTH,
	parameter logic [OVL_WIDTH-1:0] OVL_LIMIT = OVL_MAX
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// device reset pin, active low, asynchronous to sys_clk
	input wire logic deviceReset_n,
	// strap value in kilohm, sampled at reset release
	input wire logic [7:0] overcurrent_strap_resistor,
	input wire logic [1:0] outputConfig,
	// analog events from pins
	input wire logic frameStart,
	input wire logic [HB_COUNT-1:0] overcurrentEvent,
	input wire logic [CH_COUNT-1:0] dcImbalance,
	input wire logic heatWarnLevel,
	input wire logic heatShutLevel,
	input wire logic undervoltage_guard,
	input wire logic [CH_COUNT-1:0] clipDetect,
	// power stage control
	output logic [HB_COUNT-1:0] bridgeFlip,
	output logic [HB_COUNT-1:0] bridgeHiZ,
	output logic [HB_COUNT-1:0] injectPulse,
	output logic [1:0] thresholdSel,
	output logic perCycleMode,
	// status
	output logic overload_shutdown,
	output logic heat_shutdown,
	output logic heat_warning,
	// open drain pins
	output logic faultAlert_n_out,
	output logic faultAlert_n_oe,
	output logic clip_heat_warn_n_out,
	output logic clip_heat_warn_n_oe
);
	////////////////////////////////////////////////////////////////
	// input synchronisers
	localparam int SYNC_W = 6 + HB_COUNT + 2 * CH_COUNT;
	logic [SYNC_W-1:0] syncA;
	logic [SYNC_W-1:0] syncB;
	wire logic [SYNC_W-1:0] rawIn = {deviceReset_n, frameStart,
		heatWarnLevel, heatShutLevel, undervoltage_guard, 1'b0,
		overcurrentEvent, dcImbalance, clipDetect};

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			syncA <= '0;
			syncB <= '0;
		end else begin
			syncA <= rawIn;
			syncB <= syncA;
		end
	end

	wire logic rstPin_n = syncB[SYNC_W-1];
	wire logic frameLvl = syncB[SYNC_W-2];
	wire logic warnS = syncB[SYNC_W-3];
	wire logic shutS = syncB[SYNC_W-4];
	wire logic uvS = syncB[SYNC_W-5];
	wire logic [HB_COUNT-1:0] ocS = syncB[2*CH_COUNT+HB_COUNT-1:2*CH_COUNT];
	wire logic [CH_COUNT-1:0] dcS = syncB[2*CH_COUNT-1:CH_COUNT];
	wire logic [CH_COUNT-1:0] clipS = syncB[CH_COUNT-1:0];

	////////////////////////////////////////////////////////////////
	// frame edge, event edges, frame index
	// the frame index picks every fourth frame for pulse injection
	logic frameDly;
	logic [HB_COUNT-1:0] ocDly;
	logic [1:0] frameIdx;
	wire logic frameTick = frameLvl & ~frameDly;
	wire logic [HB_COUNT-1:0] ocTick = ocS & ~ocDly;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			frameDly <= 1'b0;
			ocDly <= '0;
			frameIdx <= '0;
		end else begin
			frameDly <= frameLvl;
			ocDly <= ocS;
			if (frameTick)
				frameIdx <= frameIdx + 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////
	// state machine: reset held, run, halted by heat shutdown
	apf_state_t state;
	apf_state_t next_state;
	logic heatLatch;
	wire logic running = (state == APF_ST_RUN);

	always_comb begin
		next_state = state;
		case (state)
			APF_ST_RESET: begin
				if (rstPin_n)
					next_state = APF_ST_RUN;
			end
			APF_ST_RUN: begin
				if (!rstPin_n)
					next_state = APF_ST_RESET;
				else if (heatLatch)
					next_state = APF_ST_HALT;
			end
			APF_ST_HALT: begin
				if (!rstPin_n)
					next_state = APF_ST_RESET;
			end
			default: next_state = APF_ST_RESET;
		endcase
	end

	// strap captured on the clock after reset release
	logic [7:0] strapHeld;
	logic [1:0] cfgHeld;
	wire logic capture = (state == APF_ST_RESET) & rstPin_n;

	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			state <= APF_ST_RESET;
			heatLatch <= 1'b0;
			strapHeld <= 8'h00;
			cfgHeld <= 2'h0;
		end else begin
			state <= next_state;
			if (!rstPin_n)
				heatLatch <= 1'b0;
			else if (shutS)
				heatLatch <= 1'b1;
			if (capture) begin
				strapHeld <= overcurrent_strap_resistor;
				cfgHeld <= outputConfig;
			end
		end
	end

	wire logic decPerCycle;
	wire logic [1:0] decThr;

	apf_strap_decode u_strap (
		.strapValue(strapHeld),
		.perCycleMode(decPerCycle),
		.thresholdSel(decThr)
	);

	wire logic dcEnable = (cfgHeld == APF_CFG_BRIDGE);

	////////////////////////////////////////////////////////////////
	// per half bridge limiting and overload counters
	logic [HB_COUNT-1:0] flip;
	logic [OVL_BITS-1:0] ovlCount [HB_COUNT];
	logic [HB_COUNT-1:0] hadEvent;
	logic [CH_COUNT-1:0] chanDown;

	genvar g;
	generate
		for (g = 0; g < HB_COUNT; g++) begin : g_hb
			localparam int CH = g / 2;
			wire logic ev = ocTick[g] & running;
			wire logic atMax = (ovlCount[g] == OVL_LIMIT);
			wire logic atZero = (ovlCount[g] == '0);
			wire logic dcHit = dcEnable & dcS[CH] & running;
			always_ff @(posedge sys_clk) begin
				if (sys_rst || !rstPin_n) begin
					flip[g] <= 1'b0;
					ovlCount[g] <= '0;
					hadEvent[g] <= 1'b0;
				end else begin
					if (ev & decPerCycle)
						flip[g] <= 1'b1;
					else if (frameTick)
						flip[g] <= 1'b0;
					// count down only after a frame with no event in it
					if (dcHit)
						ovlCount[g] <= OVL_LIMIT;
					else if (ev & decPerCycle & !atMax)
						ovlCount[g] <= ovlCount[g] + 1'b1;
					else if (frameTick & !hadEvent[g] & !atZero &
						!atMax)
						ovlCount[g] <= ovlCount[g] - 1'b1;
					if (ev)
						hadEvent[g] <= 1'b1;
					else if (frameTick)
						hadEvent[g] <= 1'b0;
				end
			end
		end
	endgenerate

	// channel shutdown latches
	generate
		for (g = 0; g < CH_COUNT; g++) begin : g_ch
			wire logic cntMax = (ovlCount[2*g] == OVL_LIMIT) |
				(ovlCount[2*g+1] == OVL_LIMIT);
			wire logic latchHit = !decPerCycle & running &
				(ocTick[2*g] | ocTick[2*g+1]);
			always_ff @(posedge sys_clk) begin
				// a held device reset wins over an event in the same cycle
				if (sys_rst || !rstPin_n)
					chanDown[g] <= 1'b0;
				else if (cntMax | latchHit)
					chanDown[g] <= 1'b1;
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// outputs
	logic [CH_COUNT-1:0] clipActiveInd;
	wire logic globalOff = !running | heatLatch | uvS;
	wire logic [HB_COUNT-1:0] hbDown = {{2{chanDown[1]}}, {2{chanDown[0]}}};
	wire logic [HB_COUNT-1:0] offHb = hbDown | {HB_COUNT{globalOff}};
	wire logic anyFault = heatLatch | uvS | (|chanDown);
	wire logic warnClip = warnS | (|clipActiveInd);
	wire logic injectFrame = frameTick & (frameIdx == INJECT_SLOT);
	// half bridges that sit in clipping or in per-cycle limiting
	wire logic [HB_COUNT-1:0] clipHb = {{2{clipS[1]}}, {2{clipS[0]}}};
	wire logic [HB_COUNT-1:0] limitHb = flip & {HB_COUNT{decPerCycle}};
	wire logic [HB_COUNT-1:0] injectWant = {HB_COUNT{injectFrame}} &
		~offHb & (clipHb | limitHb);

	generate
		for (g = 0; g < CH_COUNT; g++) begin : g_clip
			apf_clip_pulse u_clip (
				.sys_clk(sys_clk),
				.sys_rst(sys_rst),
				.clipActive(clipS[g] & running),
				.clipIndicate(clipActiveInd[g])
			);
		end
	endgenerate

	// power stage drive
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			bridgeFlip <= '0;
			bridgeHiZ <= '1;
			injectPulse <= '0;
		end else begin
			bridgeFlip <= flip & ~hbDown;
			bridgeHiZ <= offHb;
			injectPulse <= injectWant;
		end
	end

	// mode, status and pin drive
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			thresholdSel <= THR_MIN;
			perCycleMode <= 1'b0;
			overload_shutdown <= 1'b0;
			heat_shutdown <= 1'b0;
			heat_warning <= 1'b0;
			faultAlert_n_oe <= 1'b0;
			clip_heat_warn_n_oe <= 1'b0;
		end else begin
			thresholdSel <= decThr;
			perCycleMode <= decPerCycle;
			overload_shutdown <= |chanDown;
			heat_shutdown <= heatLatch;
			heat_warning <= warnS;
			faultAlert_n_oe <= rstPin_n & anyFault;
			clip_heat_warn_n_oe <= warnClip;
		end
	end

	// open drain: only ever pull low, pull-up is the pin's own
	assign faultAlert_n_out = 1'b0;
	assign clip_heat_warn_n_out = 1'b0;
endmodule : apf_protect
`default_nettype wire

// ==== verif/apf_protect_assertions.sv ====
`timescale 1ns/100ps
`default_nettype none
module apf_protect_assertions
	import apf_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic sys_rst,
	// inputs
	input wire logic deviceReset_n,
	input wire logic frameStart,
	input wire logic [HB_COUNT-1:0] overcurrentEvent,
	// outputs
	input wire logic [HB_COUNT-1:0] bridgeFlip,
	input wire logic [HB_COUNT-1:0] bridgeHiZ,
	input wire logic [HB_COUNT-1:0] injectPulse,
	input wire logic perCycleMode,
	input wire logic overload_shutdown,
	input wire logic heat_shutdown,
	input wire logic heat_warning,
	input wire logic faultAlert_n_out,
	input wire logic faultAlert_n_oe,
	input wire logic clip_heat_warn_n_out,
	input wire logic clip_heat_warn_n_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (sys_rst);
	logic [5:0] rstHist;
	logic rstSteady;
	// device reset pin high long enough to pass its synchroniser
	always_ff @(posedge sys_clk) begin
		rstHist <= {rstHist[4:0], deviceReset_n};
	end
	assign rstSteady = &rstHist;
	AST_PIN_DATA: assert property (!faultAlert_n_out && !clip_heat_warn_n_out)
		else $error("open drain data not low");
	AST_RST_RELEASE: assert property (!deviceReset_n [*6] |-> !faultAlert_n_oe)
		else $error("alert driven in device reset");
	AST_HEAT_WARN: assert property (heat_warning |-> ##[0:1] clip_heat_warn_n_oe)
		else $error("heat warning not on pin");
	AST_OVL_ALERT: assert property (overload_shutdown [*2] ##0 rstSteady |-> faultAlert_n_oe && bridgeHiZ != 4'h0)
		else $error("overload without alert");
	AST_HEAT_HIZ: assert property (heat_shutdown [*2] ##0 rstSteady |-> faultAlert_n_oe && bridgeHiZ == 4'hF)
		else $error("heat shutdown not all high z");
	AST_HEAT_LATCH: assert property (heat_shutdown && rstSteady |=> heat_shutdown)
		else $error("heat latch lost");
	AST_OVL_LATCH: assert property (overload_shutdown && rstSteady |=> overload_shutdown)
		else $error("overload latch lost");
	AST_FLIP_CLEAR: assert property ((overcurrentEvent == 4'h0) [*5] ##0 $rose(frameStart) ##1 (overcurrentEvent == 4'h0) [*6] |-> bridgeFlip == 4'h0)
		else $error("flip not cleared by frame");
	AST_LATCH_NOFLIP: assert property (!perCycleMode |-> bridgeFlip == 4'h0)
		else $error("flip in latched mode");
	AST_INJECT_ONE: assert property (|injectPulse |=> injectPulse == 4'h0)
		else $error("inject pulse too wide");
	AST_CLIP_WIDTH: assert property ($rose(clip_heat_warn_n_oe) |-> clip_heat_warn_n_oe [*5])
		else $error("clip pulse too short");
endmodule : apf_protect_assertions
bind apf_protect apf_protect_assertions apf_protect_assertions_inst (
	.sys_clk(sys_clk), .sys_rst(sys_rst), .deviceReset_n(deviceReset_n),
	.frameStart(frameStart), .overcurrentEvent(overcurrentEvent),
	.bridgeFlip(bridgeFlip), .bridgeHiZ(bridgeHiZ),
	.injectPulse(injectPulse), .perCycleMode(perCycleMode),
	.overload_shutdown(overload_shutdown), .heat_shutdown(heat_shutdown),
	.heat_warning(heat_warning), .faultAlert_n_out(faultAlert_n_out),
	.faultAlert_n_oe(faultAlert_n_oe),
	.clip_heat_warn_n_out(clip_heat_warn_n_out),
	.clip_heat_warn_n_oe(clip_heat_warn_n_oe)
);
`default_nettype wire

// ==== verif/apf_host_mcu.sv ====
`timescale 1ns/100ps
`default_nettype none
module apf_host_mcu (
	// open drain drive from the device
	input wire logic faultOut,
	input wire logic faultOe,
	input wire logic clipOut,
	input wire logic clipOe,
	// pin levels, pulled up when released
	output logic faultPin,
	output logic clipPin,
	// volume cut while warning shows
	output logic volumeCut
);
	assign faultPin = faultOe ? faultOut : 1'b1;
	assign clipPin = clipOe ? clipOut : 1'b1;
	assign volumeCut = !clipPin;
endmodule : apf_host_mcu
`default_nettype wire

// ==== verif/tb_apf_protect.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_apf_protect
	import apf_pkg::*;
;
	logic sys_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic deviceReset_n = 1'b0;
	logic frameStart = 1'b0;
	logic heatWarnLevel = 1'b0;
	logic heatShutLevel = 1'b0;
	logic uvGuard = 1'b0;
	logic [7:0] strap = 8'h16;
	logic [1:0] outputConfig = 2'h0;
	logic [3:0] ocEvent = 4'h0;
	logic [1:0] dcImbalance = 2'h0;
	logic [1:0] clipDetect = 2'h0;
	logic [3:0] bridgeFlip, bridgeHiZ, injectPulse;
	logic [1:0] thresholdSel;
	logic perCycleMode, ovlShut, heatShut, heatWarn;
	logic faultOut, faultOe, clipOut, clipOe, faultPin, clipPin, volCut;
	int badCount = 0;
	int samplesChecked = 0;
	int cyc = 0;
	int injCnt = 0;
	initial forever #50 sys_clk = ~sys_clk;
	apf_protect #(.OVL_LIMIT(6'h04)) apf_protect_inst (
		.sys_clk(sys_clk), .sys_rst(sys_rst), .deviceReset_n(deviceReset_n),
		.overcurrent_strap_resistor(strap), .outputConfig(outputConfig),
		.frameStart(frameStart), .overcurrentEvent(ocEvent),
		.dcImbalance(dcImbalance), .heatWarnLevel(heatWarnLevel),
		.heatShutLevel(heatShutLevel), .undervoltage_guard(uvGuard),
		.clipDetect(clipDetect), .bridgeFlip(bridgeFlip),
		.bridgeHiZ(bridgeHiZ), .injectPulse(injectPulse),
		.thresholdSel(thresholdSel), .perCycleMode(perCycleMode),
		.overload_shutdown(ovlShut), .heat_shutdown(heatShut),
		.heat_warning(heatWarn), .faultAlert_n_out(faultOut),
		.faultAlert_n_oe(faultOe), .clip_heat_warn_n_out(clipOut),
		.clip_heat_warn_n_oe(clipOe)
	);
	apf_host_mcu apf_host_mcu_inst (
		.faultOut(faultOut), .faultOe(faultOe), .clipOut(clipOut),
		.clipOe(clipOe), .faultPin(faultPin), .clipPin(clipPin),
		.volumeCut(volCut)
	);
	////////////////////////////////////////////////////////////////////////
	task automatic finish_test();
		if (badCount == 0 && samplesChecked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	always @(negedge sys_clk) begin
		cyc++;
		if (injectPulse[0] === 1'b1) begin
			injCnt++;
		end
		if (cyc == 4000) begin
			badCount++;
			finish_test();
		end
	end
	task automatic chk(input string n, input logic [7:0] e, g);
		samplesChecked++;
		if (g !== e) begin
			$display("unexpected %s: expected %h, seen %h", n, e, g);
			badCount++;
		end
	endtask : chk
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask : w
	task automatic devReset(input logic [7:0] s, input logic [1:0] c);
		deviceReset_n = 1'b0;
		strap = s;
		outputConfig = c;
		w(8);
		deviceReset_n = 1'b1;
		w(8);
	endtask : devReset
	task automatic ocPulse(input int b);
		ocEvent[b] = 1'b1;
		w(2);
		ocEvent[b] = 1'b0;
		w(4);
	endtask : ocPulse
	task automatic frame();
		frameStart = 1'b1;
		w(3);
		frameStart = 1'b0;
		w(5);
	endtask : frame
	////////////////////////////////////////////////////////////////////////
	task automatic testStrap();
		logic [7:0] s [9] = '{8'h16, 8'h18, 8'h1B, 8'h1E, 8'h2F, 8'h33,
			8'h38, 8'h40, 8'h20};
		for (int i = 0; i < 9; i++) begin
			devReset(s[i], APF_CFG_BRIDGE);
			chk("perCycleMode", 8'(i < 4), 8'(perCycleMode));
			chk("thresholdSel", 8'(i == 8 ? 3 : i % 4), 8'(thresholdSel));
		end
	endtask : testStrap
	task automatic testCycle();
		devReset(8'h16, APF_CFG_BRIDGE);
		ocPulse(0);
		chk("bridgeFlip", 8'h01, 8'(bridgeFlip));
		frame();
		chk("bridgeFlip", 8'h00, 8'(bridgeFlip));
		repeat (2) ocPulse(0);
		repeat (6) frame();
		repeat (3) ocPulse(0);
		chk("bridgeHiZ", 8'h00, 8'(bridgeHiZ));
		ocPulse(0);
		w(4);
		chk("bridgeHiZ", 8'h03, 8'(bridgeHiZ));
		chk("pins", 8'h01, {6'h00, faultPin, clipPin});
		repeat (2) frame();
		chk("overload_shutdown", 8'h01, 8'(ovlShut));
	endtask : testCycle
	task automatic testLatched();
		devReset(8'h40, APF_CFG_BRIDGE);
		ocPulse(2);
		w(4);
		chk("bridgeHiZ", 8'h0C, 8'(bridgeHiZ));
		chk("faultPin", 8'h00, 8'(faultPin));
	endtask : testLatched
	task automatic testHeat();
		devReset(8'h16, APF_CFG_BRIDGE);
		heatWarnLevel = 1'b1;
		w(6);
		chk("pins", 8'h02, {6'h00, faultPin, clipPin});
		chk("heat_warning", 8'h01, 8'(heatWarn));
		chk("volumeCut", 8'h01, 8'(volCut));
		heatShutLevel = 1'b1;
		w(6);
		heatShutLevel = 1'b0;
		w(6);
		chk("pins", 8'h00, {6'h00, faultPin, clipPin});
		chk("bridgeHiZ", 8'h0F, 8'(bridgeHiZ));
		heatWarnLevel = 1'b0;
		deviceReset_n = 1'b0;
		w(8);
		chk("faultPin", 8'h01, 8'(faultPin));
		devReset(8'h16, APF_CFG_BRIDGE);
		chk("heat_shutdown", 8'h00, 8'(heatShut));
		uvGuard = 1'b1;
		w(6);
		chk("bridgeHiZ", 8'h0F, 8'(bridgeHiZ));
		chk("faultPin", 8'h00, 8'(faultPin));
		uvGuard = 1'b0;
		w(6);
		chk("faultPin", 8'h01, 8'(faultPin));
	endtask : testHeat
	task automatic testDc();
		logic [1:0] c [3] = '{APF_CFG_BRIDGE, APF_CFG_PARALLEL, APF_CFG_SINGLE};
		for (int i = 0; i < 3; i++) begin
			devReset(8'h16, c[i]);
			dcImbalance = 2'h2;
			w(8);
			chk("bridgeHiZ", i == 0 ? 8'h0C : 8'h00, 8'(bridgeHiZ));
			dcImbalance = 2'h0;
		end
	endtask : testDc
	task automatic testClip();
		devReset(8'h16, APF_CFG_BRIDGE);
		clipDetect = 2'h1;
		w(6);
		chk("clipPin", 8'h00, 8'(clipPin));
		injCnt = 0;
		repeat (8) frame();
		chk("injectCount", 8'h02, 8'(injCnt));
		clipDetect = 2'h0;
		w(6);
		chk("clipPin", 8'h01, 8'(clipPin));
		// a one-cycle clip on channel B still shows the full onset pulse
		clipDetect = 2'h2;
		w(1);
		clipDetect = 2'h0;
		w(5);
		chk("clipPin", 8'h00, 8'(clipPin));
		w(4);
		chk("clipPin", 8'h01, 8'(clipPin));
	endtask : testClip
	////////////////////////////////////////////////////////////////////////
	initial begin
		w(16);
		sys_rst = 1'b0;
		testStrap();
		testCycle();
		testLatched();
		testHeat();
		testDc();
		testClip();
		finish_test();
	end
endmodule : tb_apf_protect
`default_nettype wire
